/* File: rtl/ecct_timer.sv */
// eight channel capture compare timer with pulse accumulator
// assumes pin inputs synchronous to clk_in; control bits are plain ports
`timescale 1ns/1ps

// Summary of operation
// - counter tick divides bus clock by 1..128
// - input channel copies counter on active edge
// - capture sets flag; irq only when enabled
// - output channel matches counter, flags, drives pin
// - action bits: set, clear, toggle, or detach
// - force strobe does action without flag
// - channel seven match drives masked data pins
// - channel seven match may reset counter
// - port writes latch; show when pin is plain
// - sixteen bit accumulator, event or gated mode
// - event mode counts selected edge on pin
// - accumulator wrap sets overflow flag, gated irq
// - event counting works with timer stopped
// - gated mode counts divide-by-64 while active
// - gated trailing edge sets input flag
// - gate clock comes from running prescaler
// - eleven active high interrupt request outputs
// - edge select meaning per accumulator mode
// - accumulator flags clear by writing one
module ecct_timer (
   input wire logic clk_in, // bus clock
   input wire logic reset_n_in, // async active low reset
   input wire logic timer_run_enable_in, // main counter runs
   input wire logic [2:0] prescale_select_in, // divide by 2**n
   input wire logic counter_reset_on_ch7_enable_in, // ch7 match clears counter
   input wire logic [ecct_pkg::CH_NUM-1:0] channel_direction_select_in, // 1 compare
   input wire logic [ecct_pkg::CH_NUM-1:0] output_action_mode_in, // action mode bits
   input wire logic [ecct_pkg::CH_NUM-1:0] output_action_level_in, // action level bits
   input wire logic [ecct_pkg::CH_NUM-1:0] capture_edge_rise_in, // capture on rise
   input wire logic [ecct_pkg::CH_NUM-1:0] capture_edge_fall_in, // capture on fall
   input wire logic [ecct_pkg::CH_NUM-1:0] channel_irq_enable_in, // per channel irq
   input wire logic [ecct_pkg::CH_NUM-1:0] channel_flag_clear_in, // one clears flag
   input wire logic [ecct_pkg::CH_NUM-1:0] force_compare_strobe_in, // pulse
   input wire logic [ecct_pkg::CH_NUM-1:0] ch7_mask_in, // pins driven by ch7
   input wire logic [ecct_pkg::CH_NUM-1:0] ch7_data_in, // levels from ch7
   input wire logic [ecct_pkg::CH_NUM-1:0] value_write_in, // load channel value
   input wire logic [ecct_pkg::CNT_W-1:0] value_wdata_in, // value for loads
   input wire logic [ecct_pkg::CH_NUM-1:0] port_write_in, // write port latch bit
   input wire logic [ecct_pkg::CH_NUM-1:0] port_wdata_in, // port latch data
   input wire logic [ecct_pkg::CH_NUM-1:0] pin_in, // channel pin levels
   input wire logic accum_enable_in, // accumulator on
   input wire logic accum_mode_select_in, // 0 event, 1 gated
   input wire logic accum_edge_select_in, // edge or level select
   input wire logic accum_overflow_irq_enable_in, // overflow irq enable
   input wire logic accum_input_irq_enable_in, // input irq enable
   input wire logic [1:0] accum_flag_register_write_in, // one clears {ovf, in}
   input wire logic counter_overflow_irq_enable_in, // counter wrap irq enable
   input wire logic counter_overflow_clear_in, // one clears wrap flag
   output logic [ecct_pkg::CNT_W-1:0] main_count_out, // free running counter
   output logic [ecct_pkg::CNT_W-1:0] pulse_accum_count_out, // accumulator
   output logic [ecct_pkg::CH_NUM*ecct_pkg::CNT_W-1:0] channel_value_out, // packed
   output logic [ecct_pkg::CH_NUM-1:0] channel_event_flag_out, // sticky flags
   output logic accum_overflow_flag_out, // sticky
   output logic accum_input_flag_out, // sticky
   output logic counter_overflow_flag_out, // sticky
   output logic [ecct_pkg::CH_NUM-1:0] pin_out, // pin drive level
   output logic [ecct_pkg::CH_NUM-1:0] pin_oe_out, // high while driving
   output logic [ecct_pkg::CH_NUM-1:0] channel_irq_out, // active high
   output logic accum_input_irq_out, // active high
   output logic accum_overflow_irq_out, // active high
   output logic counter_overflow_irq_out // active high
);
   import ecct_pkg::*;

   // ----------------------------------------------------------------
   // types and state
   // ----------------------------------------------------------------
   typedef enum {ACC_EVENT, ACC_GATED} ecct_acc_mode_type; // accumulator modes

   logic [PRE_W-1:0] prescale; // bus clock divider
   logic [CNT_W-1:0] value [CH_NUM]; // channel capture/compare values
   logic [CH_NUM-1:0] pin_prev; // last pin sample for edge detection
   logic [CH_NUM-1:0] compare_latch; // compare driven levels
   logic [CH_NUM-1:0] port_latch; // general purpose latch
   ecct_acc_mode_type acc_mode; // decoded accumulator mode

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // power-of-two tick: low bits of prescaler all ones
   function automatic logic tick_of(input logic [PRE_W-1:0] pre, input logic [2:0] sel);
      logic [PRE_W-1:0] mask;
      mask = PRE_W'((8'h01 << sel) - 8'h01);
      return (pre & mask) == mask;
   endfunction : tick_of

   wire count_tick = timer_run_enable_in && tick_of(prescale, prescale_select_in);
   wire div64_tick = timer_run_enable_in && tick_of(prescale, 3'(GATE_DIV_BIT + 1));
   wire [CH_NUM-1:0] rise = pin_in & ~pin_prev; // rising edges
   wire [CH_NUM-1:0] fall = ~pin_in & pin_prev; // falling edges
   wire [1:0] act [CH_NUM]; // action code per channel
   wire [CH_NUM-1:0] match; // compare match this tick
   wire [CH_NUM-1:0] capture; // capture event this cycle
   wire ch7_match = match[CH7]; // override source
   wire acc_pin = pin_in[CH7]; // shared channel seven pin
   wire acc_edge = accum_edge_select_in ? rise[CH7] : fall[CH7];
   wire acc_active = accum_edge_select_in ? ~acc_pin : acc_pin;
   wire acc_trail = accum_edge_select_in ? rise[CH7] : fall[CH7]; // end of active level
   wire acc_inc = accum_enable_in && ((acc_mode == ACC_EVENT) ? acc_edge
                  : (acc_active && div64_tick));
   wire acc_wrap = acc_inc && (pulse_accum_count_out == CNT_MAX);
   wire in_flag_set = accum_enable_in && ((acc_mode == ACC_GATED) ? acc_trail
                      : acc_edge);
   wire cnt_wrap = count_tick && (main_count_out == CNT_MAX);
   wire cnt_reset = ch7_match && counter_reset_on_ch7_enable_in;
   wire [CH_NUM-1:0] next_pin; // pin level after actions
   wire [CH_NUM-1:0] next_oe; // pins owned by compare logic

   assign acc_mode = accum_mode_select_in ? ACC_GATED : ACC_EVENT;

   genvar g;
   generate
      for (g = 0; g < CH_NUM; g++) begin : g_ch
         assign act[g] = {output_action_mode_in[g], output_action_level_in[g]};
         // match only on a tick so a stopped counter does not repeat events
         assign match[g] = channel_direction_select_in[g] && count_tick
                           && (main_count_out == value[g]);
         assign capture[g] = !channel_direction_select_in[g]
                             && ((capture_edge_rise_in[g] && rise[g])
                             || (capture_edge_fall_in[g] && fall[g]));
         // channel seven mask overrides other channel actions
         wire fire = (match[g] || force_compare_strobe_in[g]) && act[g] != ACT_NONE;
         wire own_lvl = (act[g] == ACT_SET) ? 1'b1
                        : (act[g] == ACT_CLEAR) ? 1'b0 : ~compare_latch[g];
         assign next_pin[g] = (ch7_match && ch7_mask_in[g]) ? ch7_data_in[g]
                              : fire ? own_lvl : compare_latch[g];
         // detached and unmasked pins fall back to the port latch
         assign next_oe[g] = (act[g] != ACT_NONE) || ch7_mask_in[g];
         assign channel_value_out[g*CNT_W +: CNT_W] = value[g];
      end
   endgenerate

   // ----------------------------------------------------------------
   // prescaler and main counter
   // ----------------------------------------------------------------
   // prescaler holds while stopped, so no gate clock without the timer
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         prescale <= PRE_ZERO;
      end else if (timer_run_enable_in) begin
         prescale <= prescale + 7'h01;
      end
   end

   // counter: reset on ch7 match wins over the tick
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         main_count_out <= CNT_ZERO;
      end else if (cnt_reset) begin
         main_count_out <= CNT_ZERO;
      end else if (count_tick) begin
         main_count_out <= main_count_out + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // channels
   // ----------------------------------------------------------------
   // values: capture has priority over a software load
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         for (int i = 0; i < CH_NUM; i++) value[i] <= CNT_ZERO;
      end else begin
         for (int i = 0; i < CH_NUM; i++) begin
            if (capture[i]) begin
               value[i] <= main_count_out;
            end else if (value_write_in[i]) begin
               value[i] <= value_wdata_in;
            end
         end
      end
   end

   // flags: a set in the clear cycle wins; forced compares leave flags alone
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         channel_event_flag_out <= '0;
         channel_irq_out <= '0;
      end else begin
         channel_event_flag_out <= (channel_event_flag_out & ~channel_flag_clear_in)
                                   | capture | match;
         channel_irq_out <= ((channel_event_flag_out & ~channel_flag_clear_in)
                            | capture | match) & channel_irq_enable_in;
      end
   end

   // pins, port latch and edge history
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_prev <= '0;
         compare_latch <= '0;
         port_latch <= '0;
         pin_out <= '0;
         pin_oe_out <= '0;
      end else begin
         pin_prev <= pin_in;
         compare_latch <= next_pin;
         port_latch <= (port_latch & ~port_write_in) | (port_wdata_in & port_write_in);
         pin_out <= (next_oe & next_pin) | (~next_oe & port_latch);
         pin_oe_out <= next_oe | channel_direction_select_in;
      end
   end

   // ----------------------------------------------------------------
   // pulse accumulator
   // ----------------------------------------------------------------
   // count runs from the pin even with the timer stopped in event mode
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pulse_accum_count_out <= CNT_ZERO;
      end else if (acc_inc) begin
         pulse_accum_count_out <= pulse_accum_count_out + 16'h0001;
      end
   end

   // sticky flags; hardware set beats write-one clear
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         accum_overflow_flag_out <= 1'b0;
         accum_input_flag_out <= 1'b0;
         counter_overflow_flag_out <= 1'b0;
         accum_overflow_irq_out <= 1'b0;
         accum_input_irq_out <= 1'b0;
         counter_overflow_irq_out <= 1'b0;
      end else begin
         accum_overflow_flag_out <= acc_wrap
            || (accum_overflow_flag_out && !accum_flag_register_write_in[1]);
         accum_input_flag_out <= in_flag_set
            || (accum_input_flag_out && !accum_flag_register_write_in[0]);
         counter_overflow_flag_out <= cnt_wrap
            || (counter_overflow_flag_out && !counter_overflow_clear_in);
         accum_overflow_irq_out <= accum_overflow_irq_enable_in && (acc_wrap
            || (accum_overflow_flag_out && !accum_flag_register_write_in[1]));
         accum_input_irq_out <= accum_input_irq_enable_in && (in_flag_set
            || (accum_input_flag_out && !accum_flag_register_write_in[0]));
         counter_overflow_irq_out <= counter_overflow_irq_enable_in && (cnt_wrap
            || (counter_overflow_flag_out && !counter_overflow_clear_in));
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_wrap_tick;
      count_tick && main_count_out == CNT_MAX && !cnt_reset;
   endsequence

   property p_counter_wrap;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_wrap_tick |=> main_count_out == CNT_ZERO && counter_overflow_flag_out;
   endproperty
   a_counter_wrap: assert property (p_counter_wrap) else $error("wrap missed");

   property p_capture;
      @(posedge clk_in) disable iff (!reset_n_in)
      capture[0] |=> value[0] == $past(main_count_out) && channel_event_flag_out[0];
   endproperty
   a_capture: assert property (p_capture) else $error("capture wrong");

   property p_ch_irq;
      @(posedge clk_in) disable iff (!reset_n_in)
      channel_irq_out[1] |-> channel_event_flag_out[1] && $past(channel_irq_enable_in[1]);
   endproperty
   a_ch_irq: assert property (p_ch_irq) else $error("irq without enable");

   property p_ch7_reset;
      @(posedge clk_in) disable iff (!reset_n_in)
      cnt_reset |=> main_count_out == CNT_ZERO;
   endproperty
   a_ch7_reset: assert property (p_ch7_reset) else $error("ch7 reset missed");

   property p_ch7_override;
      @(posedge clk_in) disable iff (!reset_n_in)
      ch7_match && ch7_mask_in[3] |=> pin_out[3] == $past(ch7_data_in[3]);
   endproperty
   a_ch7_override: assert property (p_ch7_override) else $error("override lost");

   property p_force_noflag;
      @(posedge clk_in) disable iff (!reset_n_in)
      force_compare_strobe_in[2] && !match[2] && !capture[2]
         && !channel_event_flag_out[2] |=> !channel_event_flag_out[2];
   endproperty
   a_force_noflag: assert property (p_force_noflag) else $error("force set flag");

   property p_acc_wrap;
      @(posedge clk_in) disable iff (!reset_n_in)
      acc_wrap |=> pulse_accum_count_out == CNT_ZERO && accum_overflow_flag_out;
   endproperty
   a_acc_wrap: assert property (p_acc_wrap) else $error("acc wrap missed");

   property p_gated_stop;
      @(posedge clk_in) disable iff (!reset_n_in)
      accum_mode_select_in && !timer_run_enable_in
         |=> pulse_accum_count_out == $past(pulse_accum_count_out);
   endproperty
   a_gated_stop: assert property (p_gated_stop) else $error("gated without timer");

   property p_flag_clear;
      @(posedge clk_in) disable iff (!reset_n_in)
      accum_flag_register_write_in[0] && !in_flag_set |=> !accum_input_flag_out;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("clear failed");

   // gate open with a divide-by-64 pulse and room left before the wrap
   sequence s_gate_tick;
      accum_enable_in && accum_mode_select_in && acc_active && div64_tick
         && pulse_accum_count_out != CNT_MAX;
   endsequence

   property p_gated_tick;
      @(posedge clk_in) disable iff (!reset_n_in)
      s_gate_tick |=> pulse_accum_count_out == $past(pulse_accum_count_out) + 16'h0001;
   endproperty
   a_gated_tick: assert property (p_gated_tick) else $error("gated tick lost");

   property p_gate_closed;
      @(posedge clk_in) disable iff (!reset_n_in)
      accum_enable_in && accum_mode_select_in && !acc_active
         |=> pulse_accum_count_out == $past(pulse_accum_count_out);
   endproperty
   a_gate_closed: assert property (p_gate_closed) else $error("closed gate count");

   property p_trail_flag;
      @(posedge clk_in) disable iff (!reset_n_in)
      accum_enable_in && accum_mode_select_in && acc_trail |=> accum_input_flag_out;
   endproperty
   a_trail_flag: assert property (p_trail_flag) else $error("trail flag missed");

   // a stopped timer must freeze the count, or compares would fire late
   property p_stopped;
      @(posedge clk_in) disable iff (!reset_n_in)
      !timer_run_enable_in |=> main_count_out == $past(main_count_out);
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter moved");

   // pins not owned by compare logic show the port latch of the cycle before
   property p_port_view;
      @(posedge clk_in) disable iff (!reset_n_in)
      ((pin_out ^ $past(port_latch)) & ~$past(next_oe)) == '0;
   endproperty
   a_port_view: assert property (p_port_view) else $error("port latch not shown");

endmodule : ecct_timer

/* File: inc/ecct_pkg.sv */
// package for the eight channel capture compare timer
// assumes a single bus clock domain and synchronous pin inputs
package ecct_pkg;
   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int CH_NUM = 8; // channel count
   localparam int CNT_W = 16; // counter width
   localparam int PRE_W = 7; // prescaler width, divide up to 128
   localparam int CH7 = 7; // channel with override and reset powers
   localparam int GATE_DIV_BIT = 5; // prescaler bit whose carry gives bus/64
   localparam logic [15:0] CNT_MAX = 16'hffff; // wrap point of counters
   localparam logic [15:0] CNT_ZERO = 16'h0000; // reset value of counters
   localparam logic [6:0] PRE_ZERO = 7'h00; // prescaler reset value
   // output action codes {mode, level}
   localparam logic [1:0] ACT_NONE = 2'h0; // pin detached
   localparam logic [1:0] ACT_TOGGLE = 2'h1; // toggle on compare
   localparam logic [1:0] ACT_CLEAR = 2'h2; // drive low on compare
   localparam logic [1:0] ACT_SET = 2'h3; // drive high on compare
endpackage : ecct_pkg

/* File: bench/ecct_pin_model.sv */
// external event source that drives the channel pins of the timer
// assumes the bench clock is the bus clock and pins are sampled on its rise
`timescale 1ns/1ps
module ecct_pin_model (
   input wire logic clk_in, // bus clock
   output logic [7:0] pin_out // event levels seen by the timer
);
   // ----------------------------------------------------------------
   // pulse source
   // ----------------------------------------------------------------
   // lines rest low between pulses, like an idle sensor output
   initial pin_out = 8'h00;
   // n high pulses of w cycles each; w is raised to three, though the edge
   // detector compares each pin sample with the last and catches a one-clock pulse
   task automatic pulse(input int ch, input int n, input int w);
      int k;
      for (k = 0; k < n; k++) begin
         @(posedge clk_in);
         #2 pin_out[ch] = 1'b1;
         repeat ((w < 3) ? 3 : w) @(posedge clk_in);
         #2 pin_out[ch] = 1'b0;
         repeat (3) @(posedge clk_in);
      end
      #2; // hand back off the edge so the caller never races the design
   endtask : pulse
endmodule : ecct_pin_model

/* File: bench/ecct_timer_tb_top.sv */
// self-checking bench for the eight channel capture compare timer
// assumes package, design and pin model are compiled first; one bus clock
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
   $display("wrong value at %0t got %h exp %h", $time, (g), (e)); end end
`define WAITC(c, n) begin i = 0; while ((c) !== 1'b1 && i < (n)) begin \
   step(1); i++; end if (i >= (n)) begin err_count++; wrap_up(); end end
module ecct_timer_tb_top;
   import ecct_pkg::*;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk_in = 1'b0; // bus clock
   logic reset_n_in = 1'b0; // held low for six cycles
   logic run = 1'b0, counter_reset_on_ch7_enable = 1'b0, aen = 1'b0, amod = 1'b0, aedge = 1'b0; // levels
   logic aovie = 1'b1, ainie = 1'b0, covie = 1'b1, cclr = 1'b0; // enables, clear
   logic [2:0] pre = 3'h0; // prescale select
   logic [1:0] aclr = 2'h0; // accumulator flag write-one pulses
   logic [7:0] dir = 8'h00, om = 8'h00, ol = 8'h00, rise = 8'h00, ien = 8'h00;
   logic [7:0] fclr = 8'h00, foc = 8'h00, m7 = 8'h00, d7 = 8'h00, vwr = 8'h00, cfall = 8'h00;
   logic [7:0] pwr = 8'h00, pdat = 8'h00, pins, pin_o, oe, cirq, cflag;
   logic [15:0] vdat = 16'h0000, cnt, acc, base;
   logic [127:0] cval; // packed channel values
   logic aovf, ainf, covf, ainirq, aovirq, covirq;
   int err_count = 0; // mismatches
   int n_checks = 0; // comparisons
   int i; // wait loop index
   // ----------------------------------------------------------------
   // design and pin source
   // ----------------------------------------------------------------
   // both capture edge enables are driven so each edge path gets its own test
   ecct_timer ecct_timer_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
      .timer_run_enable_in(run), .prescale_select_in(pre),
      .counter_reset_on_ch7_enable_in(counter_reset_on_ch7_enable), .channel_direction_select_in(dir),
      .output_action_mode_in(om), .output_action_level_in(ol),
      .capture_edge_rise_in(rise), .capture_edge_fall_in(cfall),
      .channel_irq_enable_in(ien), .channel_flag_clear_in(fclr),
      .force_compare_strobe_in(foc), .ch7_mask_in(m7), .ch7_data_in(d7),
      .value_write_in(vwr), .value_wdata_in(vdat), .port_write_in(pwr),
      .port_wdata_in(pdat), .pin_in(pins), .accum_enable_in(aen),
      .accum_mode_select_in(amod), .accum_edge_select_in(aedge),
      .accum_overflow_irq_enable_in(aovie), .accum_input_irq_enable_in(ainie),
      .accum_flag_register_write_in(aclr), .counter_overflow_irq_enable_in(covie),
      .counter_overflow_clear_in(cclr), .main_count_out(cnt),
      .pulse_accum_count_out(acc), .channel_value_out(cval),
      .channel_event_flag_out(cflag), .accum_overflow_flag_out(aovf),
      .accum_input_flag_out(ainf), .counter_overflow_flag_out(covf),
      .pin_out(pin_o), .pin_oe_out(oe), .channel_irq_out(cirq),
      .accum_input_irq_out(ainirq), .accum_overflow_irq_out(aovirq),
      .counter_overflow_irq_out(covirq));
   ecct_pin_model ecct_pin_model_inst (.clk_in(clk_in), .pin_out(pins));
   // ----------------------------------------------------------------
   // clock and access tasks
   // ----------------------------------------------------------------
   initial forever #25 clk_in = ~clk_in; // 50 ns period
   // inputs move 2 ns after the edge so no race with the design's sampling
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #2;
   endtask : step
   // one-cycle value load; the idle cycle after it keeps strobes apart
   task automatic load(input int ch, input logic [15:0] v);
      vdat = v;
      vwr = 8'h01 << ch;
      step(1);
      vwr = 8'h00;
      step(1);
   endtask : load
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : wrap_up
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      step(6);
      reset_n_in = 1'b1;
      step(1);
      `CHK({cnt, acc, cflag, oe, cirq}, 56'h0);
      $display("test reset done");
      // divide by eight: 64 bus clocks give 8 ticks whatever the phase
      run = 1'b1;
      pre = 3'h3;
      step(4);
      base = cnt;
      step(64);
      `CHK(cnt, base + 16'h0008);
      pre = 3'h0;
      `WAITC(covf, 70000)
      step(1);
      `CHK(covirq, 1'b1);
      cclr = 1'b1;
      step(1);
      cclr = 1'b0;
      step(1);
      `CHK(covf, 1'b0);
      $display("test counter done");
      // ch1 set, ch2 toggle, ch4 clear, ch7 resets the counter at 0x100
      load(1, 16'h0080);
      load(2, 16'hffff);
      load(4, 16'h0050);
      load(7, 16'h0100);
      `CHK(cval[127:112], 16'h0100);
      om = 8'h12;
      ol = 8'h06;
      dir = 8'h96;
      m7 = 8'h08; // ch7 own pin kept out of the mask
      d7 = 8'h08;
      ien = 8'hfe;
      counter_reset_on_ch7_enable = 1'b1;
      pwr = 8'h10;
      pdat = 8'h10;
      step(1);
      pwr = 8'h00;
      `WAITC(cflag[7], 600)
      step(1);
      `CHK(cnt <= 16'h0003, 1'b1);
      `CHK(pin_o[3], 1'b1);
      `CHK({pin_o[1], cflag[1], cirq[1]}, 3'h7);
      `CHK({pin_o[4], oe[4]}, 2'h1);
      // detaching ch4 lets the held port latch reach the pin
      dir = 8'h86;
      om = 8'h02;
      step(2);
      `CHK(pin_o[4], 1'b1);
      foc = 8'h04;
      step(1);
      foc = 8'h00;
      step(1);
      `CHK({pin_o[2], cflag[2]}, 2'h2);
      fclr = 8'h02;
      step(1);
      fclr = 8'h00;
      step(1);
      `CHK(cflag[1], 1'b0);
      $display("test compare done");
      // stopped counter makes the captured value predictable
      run = 1'b0;
      rise = 8'h01;
      step(2);
      base = cnt;
      ecct_pin_model_inst.pulse(0, 1, 4);
      `CHK({cval[15:0], cflag[0], cirq[0]}, {base, 2'h2});
      ien = 8'hff;
      step(2);
      `CHK(cirq[0], 1'b1);
      // falling edge only, over a fresh load, must capture the held count
      rise = 8'h00;
      cfall = 8'h01;
      load(0, 16'h1234);
      ecct_pin_model_inst.pulse(0, 1, 4);
      `CHK(cval[15:0], base);
      $display("test capture done");
      // event mode with the timer stopped: rising, then falling edges
      aen = 1'b1;
      aedge = 1'b1;
      step(1);
      ecct_pin_model_inst.pulse(7, 3, 3);
      `CHK({acc, ainf}, {16'h0003, 1'b1});
      aedge = 1'b0;
      ecct_pin_model_inst.pulse(7, 2, 3);
      `CHK(acc, 16'h0005);
      // writing the overflow bit alone must leave the input flag set
      aclr = 2'h2;
      step(1);
      aclr = 2'h1;
      `CHK(ainf, 1'b1);
      step(1);
      aclr = 2'h0;
      `CHK(ainf, 1'b0);
      $display("test event done");
      // gated on high level: no ticks while stopped, then about four in 256
      amod = 1'b1;
      ainie = 1'b1;
      base = acc;
      ecct_pin_model_inst.pulse(7, 1, 200);
      `CHK({acc, ainf, ainirq}, {base, 2'h3});
      run = 1'b1;
      ecct_pin_model_inst.pulse(7, 1, 256);
      `CHK((acc - base) >= 16'h3 && (acc - base) <= 16'h5, 1'b1);
      `CHK({aovf, aovirq}, 2'h0);
      $display("test gated done");
      wrap_up();
   end
endmodule : ecct_timer_tb_top
